// *** ocd_regs.vh ***
// Register offsets, field positions and reset values of the channel 7 configuration set.
`ifndef OCD_REGS_VH
`define OCD_REGS_VH

`define OCD_ADDR_W              6
`define OCD_DATA_W              16

`define OCD_OFF_CH6_FRAC_HIGH   6'h10
`define OCD_OFF_CH6_FRAC_LOW    6'h11
`define OCD_OFF_CH7_CONTROL     6'h12
`define OCD_OFF_CH7_DIVIDER     6'h13
`define OCD_OFF_CH7_FRAC_LOW    6'h14

`define OCD_MASK_CH6_FRAC_HIGH  16'h000F
`define OCD_MASK_CH6_FRAC_LOW   16'hFFFF
`define OCD_MASK_CH7_CONTROL    16'h1FDF
`define OCD_MASK_CH7_DIVIDER    16'h0FFF
`define OCD_MASK_CH7_FRAC_LOW   16'hFFFF

`define OCD_RST_CH6_FRAC_HIGH   16'h0000
`define OCD_RST_CH6_FRAC_LOW    16'h0000
`define OCD_RST_CH7_CONTROL     16'h0000
`define OCD_RST_CH7_DIVIDER     16'h0000
`define OCD_RST_CH7_FRAC_LOW    16'h0000

`define OCD_CTL_PRESCALE_HI     12
`define OCD_CTL_PRESCALE_LO     10
`define OCD_CTL_FRAC_EN         9
`define OCD_CTL_SLEW            8
`define OCD_CTL_NEG_EN          7
`define OCD_CTL_POS_EN          6
`define OCD_CTL_DRIVER_HI       4
`define OCD_CTL_DRIVER_LO       3
`define OCD_CTL_STATE_HI        2
`define OCD_CTL_STATE_LO        1
`define OCD_CTL_SUPPLY          0

`define OCD_DIV_INT_HI          11
`define OCD_DIV_INT_LO          4
`define OCD_DIV_FRAC_HI         3
`define OCD_DIV_FRAC_LO         0

`define OCD_PRESCALE_DIV2       3'h0
`define OCD_PRESCALE_DIV3       3'h1
`define OCD_PRESCALE_DIV1       3'h7

`define OCD_DRIVER_LVCMOS       2'h2
`define OCD_DRIVER_HCSL         2'h3

`define OCD_STATE_OFF           2'h0
`define OCD_STATE_CLOCK         2'h1
`define OCD_STATE_LOW           2'h2
`define OCD_STATE_HIGH          2'h3

`endif

// *** ocd_cfg_reg.v ***
// One configuration register with a writable-bit mask and a constant reset value.
`timescale 1ns/1ps
`default_nettype none

module ocd_cfg_reg #(
  parameter [15:0] RESET_VALUE = 16'h0000,
  parameter [15:0] WRITE_MASK  = 16'hFFFF
) (
  input  wire        clk_sys,
  input  wire        resetn,
  input  wire        wrEn,
  input  wire [15:0] wrData,
  output wire [15:0] value
);

  reg [15:0] value_ff;

  // Bits outside the mask are never stored, so reserved bits always read as zero.
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      value_ff <= RESET_VALUE;
    end else if (wrEn) begin
      value_ff <= wrData & WRITE_MASK;
    end
  end

  assign value = value_ff;

endmodule

`default_nettype wire

// *** ocd_channel_config.v ***
// Channel 7 output configuration registers with decoded divider and driver settings.
//
// Functional notes
// RULE_01: Pre-divider code 000 divides by 2, 001 by 3, and 111 by 1 only when the oscillator is at or below 2.4 GHz.
// RULE_02: The channel 7 pre-divider is bypassed whenever the fractional enable bit 9 is clear.
// RULE_03: The host writes only codes 000, 001 or 111 into the pre-divider field.
// RULE_04: Control bit 9 enables the channel 7 fractional divider when set and disables it when clear.
// RULE_05: Control bit 8 selects normal single-ended slew when clear and slow slew when set.
// RULE_06: Bit 6 enables the positive single-ended side, bit 7 the negative side, which works only with the positive side on.
// RULE_07: Driver field bits 4:3 select LVDS for 00 and 01, LVCMOS for 10 and HCSL for 11.
// RULE_08: State field bits 2:1 give off for 00, clocking for 01, static low for 10 and static high for 11.
// RULE_09: Control bit 0 selects the 1.8 V supply range when clear and the 2.5/3.3 V range when set.
// RULE_10: Divider bits 11:4 hold an integer divide ratio equal to the stored value plus one.
// RULE_11: Divider bits 3:0 hold bits 19 to 16 of the channel 7 fractional value.
// RULE_12: The first register of the set holds bits 15 to 0 of the channel 6 fractional value.
// RULE_13: The host writes zero to control bits 15:13 and 5 and to divider bits 15:12.
// RULE_14: The register after the set holds bits 15 to 0 of the channel 7 fractional value.
// RULE_15: The register before the set holds bits 19 to 16 of the channel 6 fractional value in its low four bits.
`timescale 1ns/1ps
`default_nettype none
`include "ocd_regs.vh"

module ocd_channel_config (
  input  wire        clk_sys,
  input  wire        resetn,
  input  wire        regWrEn,
  input  wire        regRdEn,
  input  wire [5:0]  regAddr,
  input  wire [15:0] regWrData,
  input  wire        vcoLowRange,
  output reg  [15:0] regRdData_ff,
  output reg         regRdValid_ff,
  output reg  [19:0] ch6FractionValue_ff,
  output reg  [19:0] ch7FractionValue_ff,
  output reg  [8:0]  ch7IntegerDivide_ff,
  output reg         ch7FractionEnable_ff,
  output reg  [1:0]  ch7PrescaleDivide_ff,
  output reg         ch7PrescaleBypass_ff,
  output reg         ch7PrescaleFault_ff,
  output reg         ch7SingleEndedSlow_ff,
  output reg         ch7PositiveSideOn_ff,
  output reg         ch7NegativeSideOn_ff,
  output reg         ch7DriverLvds_ff,
  output reg         ch7DriverLvcmos_ff,
  output reg         ch7DriverHcsl_ff,
  output reg         ch7OutputClocking_ff,
  output reg         ch7OutputStatic_ff,
  output reg         ch7StaticLevel_ff,
  output reg         ch7SupplyHigh_ff
);

  wire [15:0] ch6FracHigh;
  wire [15:0] ch6FracLow;
  wire [15:0] ch7Control;
  wire [15:0] ch7Divider;
  wire [15:0] ch7FracLow;

  wire selCh6FracHigh = (regAddr == `OCD_OFF_CH6_FRAC_HIGH);
  wire selCh6FracLow  = (regAddr == `OCD_OFF_CH6_FRAC_LOW);
  wire selCh7Control  = (regAddr == `OCD_OFF_CH7_CONTROL);
  wire selCh7Divider  = (regAddr == `OCD_OFF_CH7_DIVIDER);
  wire selCh7FracLow  = (regAddr == `OCD_OFF_CH7_FRAC_LOW);

  // Storage masks drop reserved bits, so a careless host write cannot reach them.
  ocd_cfg_reg #(
    .RESET_VALUE (`OCD_RST_CH6_FRAC_HIGH),
    .WRITE_MASK  (`OCD_MASK_CH6_FRAC_HIGH)
  ) uCh6FracHigh (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .wrEn    (regWrEn & selCh6FracHigh),
    .wrData  (regWrData),
    .value   (ch6FracHigh)
  );

  ocd_cfg_reg #(
    .RESET_VALUE (`OCD_RST_CH6_FRAC_LOW),
    .WRITE_MASK  (`OCD_MASK_CH6_FRAC_LOW)
  ) uCh6FracLow (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .wrEn    (regWrEn & selCh6FracLow),
    .wrData  (regWrData),
    .value   (ch6FracLow)
  );

  ocd_cfg_reg #(
    .RESET_VALUE (`OCD_RST_CH7_CONTROL),
    .WRITE_MASK  (`OCD_MASK_CH7_CONTROL)
  ) uCh7Control (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .wrEn    (regWrEn & selCh7Control),
    .wrData  (regWrData),
    .value   (ch7Control)
  );

  ocd_cfg_reg #(
    .RESET_VALUE (`OCD_RST_CH7_DIVIDER),
    .WRITE_MASK  (`OCD_MASK_CH7_DIVIDER)
  ) uCh7Divider (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .wrEn    (regWrEn & selCh7Divider),
    .wrData  (regWrData),
    .value   (ch7Divider)
  );

  ocd_cfg_reg #(
    .RESET_VALUE (`OCD_RST_CH7_FRAC_LOW),
    .WRITE_MASK  (`OCD_MASK_CH7_FRAC_LOW)
  ) uCh7FracLow (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .wrEn    (regWrEn & selCh7FracLow),
    .wrData  (regWrData),
    .value   (ch7FracLow)
  );

  wire [2:0] prescaleCode = ch7Control[`OCD_CTL_PRESCALE_HI:`OCD_CTL_PRESCALE_LO];
  wire       fracEnable   = ch7Control[`OCD_CTL_FRAC_EN]; // see RULE_04
  wire [1:0] driverCode   = ch7Control[`OCD_CTL_DRIVER_HI:`OCD_CTL_DRIVER_LO];
  wire [1:0] stateCode    = ch7Control[`OCD_CTL_STATE_HI:`OCD_CTL_STATE_LO];
  wire       posSide      = ch7Control[`OCD_CTL_POS_EN];
  wire [7:0] intField     = ch7Divider[`OCD_DIV_INT_HI:`OCD_DIV_INT_LO];
  wire       negSide      = ch7Control[`OCD_CTL_NEG_EN];
  wire       slowSlew     = ch7Control[`OCD_CTL_SLEW];
  wire       supplyHigh   = ch7Control[`OCD_CTL_SUPPLY];
  wire [3:0] fracHighNib  = ch7Divider[`OCD_DIV_FRAC_HI:`OCD_DIV_FRAC_LO];

  reg [1:0]  nxt_prescaleDivide;
  reg        nxt_prescaleFault;
  reg [15:0] nxt_rdData;
  reg [19:0] nxt_ch6FractionValue;
  reg [19:0] nxt_ch7FractionValue;
  reg [8:0]  nxt_ch7IntegerDivide;
  reg        nxt_ch7SingleEndedSlow;
  reg        nxt_ch7PositiveSideOn;
  reg        nxt_ch7NegativeSideOn;
  reg        nxt_ch7DriverLvds;
  reg        nxt_ch7DriverLvcmos;
  reg        nxt_ch7DriverHcsl;
  reg        nxt_ch7OutputClocking;
  reg        nxt_ch7OutputStatic;
  reg        nxt_ch7StaticLevel;
  reg        nxt_ch7SupplyHigh;

  // While bit 9 is set, a reserved or disallowed code falls back to divide-by-2 and raises the fault flag,
  // because a unity ratio above the oscillator limit would overrun the fractional stage.
  always @* begin
    nxt_prescaleDivide = 2'h2;
    nxt_prescaleFault  = 1'b0;
    case (prescaleCode)
      `OCD_PRESCALE_DIV2: nxt_prescaleDivide = 2'h2; // see RULE_01
      `OCD_PRESCALE_DIV3: nxt_prescaleDivide = 2'h3; // see RULE_01
      `OCD_PRESCALE_DIV1: begin
        if (vcoLowRange) begin
          nxt_prescaleDivide = 2'h1; // see RULE_01
        end else begin
          nxt_prescaleFault = 1'b1;
        end
      end
      default: nxt_prescaleFault = 1'b1; // see RULE_03
    endcase
    if (!fracEnable) begin
      nxt_prescaleDivide = 2'h1; // see RULE_02
      nxt_prescaleFault  = 1'b0;
    end
  end

  always @* begin
    nxt_rdData = 16'h0000;
    case (1'b1)
      selCh6FracHigh: nxt_rdData = ch6FracHigh;
      selCh6FracLow:  nxt_rdData = ch6FracLow;
      selCh7Control:  nxt_rdData = ch7Control;
      selCh7Divider:  nxt_rdData = ch7Divider;
      selCh7FracLow:  nxt_rdData = ch7FracLow;
      default:        nxt_rdData = 16'h0000;
    endcase
  end

  // The fraction words are rebuilt from their two halves on every edge. Nothing makes
  // the pair atomic, so between the two host writes a word mixes old and new halves.
  always @* begin
    nxt_ch6FractionValue = {ch6FracHigh[3:0], ch6FracLow}; // see RULE_12, see RULE_15
    nxt_ch7FractionValue = {fracHighNib, ch7FracLow}; // see RULE_11, see RULE_14
    nxt_ch7IntegerDivide = {1'b0, intField} + 9'h001; // see RULE_10
  end

  // The negative side is held off unless the positive side is on as well; the stored
  // bit still reads back exactly as the host wrote it.
  always @* begin
    nxt_ch7SingleEndedSlow = slowSlew; // see RULE_05
    nxt_ch7PositiveSideOn  = posSide; // see RULE_06
    nxt_ch7NegativeSideOn  = 1'b0;
    if (posSide) begin
      nxt_ch7NegativeSideOn = negSide; // see RULE_06
    end
    nxt_ch7SupplyHigh      = supplyHigh; // see RULE_09
  end

  // Codes 00 and 01 both give the differential driver, so only the two upper codes
  // need an arm of their own.
  always @* begin
    nxt_ch7DriverLvds   = 1'b1;
    nxt_ch7DriverLvcmos = 1'b0;
    nxt_ch7DriverHcsl   = 1'b0;
    case (driverCode)
      `OCD_DRIVER_LVCMOS: begin
        nxt_ch7DriverLvds   = 1'b0;
        nxt_ch7DriverLvcmos = 1'b1; // see RULE_07
      end
      `OCD_DRIVER_HCSL: begin
        nxt_ch7DriverLvds = 1'b0;
        nxt_ch7DriverHcsl = 1'b1; // see RULE_07
      end
      default: begin
        nxt_ch7DriverLvds   = 1'b1; // see RULE_07
        nxt_ch7DriverLvcmos = 1'b0;
        nxt_ch7DriverHcsl   = 1'b0;
      end
    endcase
  end

  // A static level only means something while the output is not clocking, so the two
  // decodes are kept mutually exclusive.
  always @* begin
    nxt_ch7OutputClocking = 1'b0;
    nxt_ch7OutputStatic   = 1'b0;
    nxt_ch7StaticLevel    = 1'b0;
    case (stateCode)
      `OCD_STATE_CLOCK: nxt_ch7OutputClocking = 1'b1; // see RULE_08
      `OCD_STATE_LOW:   nxt_ch7OutputStatic   = 1'b1; // see RULE_08
      `OCD_STATE_HIGH: begin
        nxt_ch7OutputStatic = 1'b1;
        nxt_ch7StaticLevel  = 1'b1; // see RULE_08
      end
      default: begin
        nxt_ch7OutputClocking = 1'b0; // see RULE_08
        nxt_ch7OutputStatic   = 1'b0;
        nxt_ch7StaticLevel    = 1'b0;
      end
    endcase
  end

  // Read data holds between reads, so a slow serial engine may shift it out at leisure.
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      regRdData_ff  <= 16'h0000;
      regRdValid_ff <= 1'b0;
    end else begin
      regRdValid_ff <= regRdEn;
      if (regRdEn) begin
        regRdData_ff <= nxt_rdData;
      end
    end
  end

  // Decoded settings trail the stored words by one edge, so the divider datapath only
  // ever sees a registered copy and never a decoder glitch.
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ch6FractionValue_ff   <= 20'h00000;
      ch7FractionValue_ff   <= 20'h00000;
      ch7IntegerDivide_ff   <= 9'h001;
      ch7FractionEnable_ff  <= 1'b0;
      ch7PrescaleDivide_ff  <= 2'h1;
      ch7PrescaleBypass_ff  <= 1'b1;
      ch7PrescaleFault_ff   <= 1'b0;
      ch7SingleEndedSlow_ff <= 1'b0;
      ch7PositiveSideOn_ff  <= 1'b0;
      ch7NegativeSideOn_ff  <= 1'b0;
      ch7DriverLvds_ff      <= 1'b1;
      ch7DriverLvcmos_ff    <= 1'b0;
      ch7DriverHcsl_ff      <= 1'b0;
      ch7OutputClocking_ff  <= 1'b0;
      ch7OutputStatic_ff    <= 1'b0;
      ch7StaticLevel_ff     <= 1'b0;
      ch7SupplyHigh_ff      <= 1'b0;
    end else begin
      ch6FractionValue_ff   <= nxt_ch6FractionValue;
      ch7FractionValue_ff   <= nxt_ch7FractionValue;
      ch7IntegerDivide_ff   <= nxt_ch7IntegerDivide;
      ch7FractionEnable_ff  <= fracEnable; // see RULE_04
      ch7PrescaleDivide_ff  <= nxt_prescaleDivide;
      ch7PrescaleBypass_ff  <= ~fracEnable; // see RULE_02
      ch7PrescaleFault_ff   <= nxt_prescaleFault;
      ch7SingleEndedSlow_ff <= nxt_ch7SingleEndedSlow;
      ch7PositiveSideOn_ff  <= nxt_ch7PositiveSideOn;
      ch7NegativeSideOn_ff  <= nxt_ch7NegativeSideOn;
      ch7DriverLvds_ff      <= nxt_ch7DriverLvds;
      ch7DriverLvcmos_ff    <= nxt_ch7DriverLvcmos;
      ch7DriverHcsl_ff      <= nxt_ch7DriverHcsl;
      ch7OutputClocking_ff  <= nxt_ch7OutputClocking;
      ch7OutputStatic_ff    <= nxt_ch7OutputStatic;
      ch7StaticLevel_ff     <= nxt_ch7StaticLevel;
      ch7SupplyHigh_ff      <= nxt_ch7SupplyHigh;
    end
  end

endmodule

`default_nettype wire

// *** ocd_chk_props.sv ***
// Concurrent property checker for the channel 7 configuration registers.
`timescale 1ns/1ps
`default_nettype none
module ocd_chk (
  input wire logic        clk_sys,
  input wire logic        resetn,
  input wire logic        regWrEn,
  input wire logic [5:0]  regAddr,
  input wire logic [15:0] regWrData,
  input wire logic [19:0] ch7FractionValue_ff,
  input wire logic [8:0]  ch7IntegerDivide_ff,
  input wire logic        ch7FractionEnable_ff,
  input wire logic [1:0]  ch7PrescaleDivide_ff,
  input wire logic        ch7PrescaleBypass_ff,
  input wire logic        ch7PositiveSideOn_ff,
  input wire logic        ch7NegativeSideOn_ff,
  input wire logic        ch7DriverLvds_ff,
  input wire logic        ch7DriverLvcmos_ff,
  input wire logic        ch7DriverHcsl_ff
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // Decoded outputs trail the stored word by one edge, hence the extra cycle.
  sequence wrAt(a);
    regWrEn && regAddr == a;
  endsequence
  AST_FRAC_EN: assert property (wrAt(6'h12) |=> ##1
    ch7FractionEnable_ff == $past(regWrData[9], 2)) else $error("fraction enable wrong");
  AST_BYPASS: assert property (wrAt(6'h12) |=> ##1
    ch7PrescaleBypass_ff == !$past(regWrData[9], 2)) else $error("bypass not tied to enable");
  AST_BYPASS_RATIO: assert property (ch7PrescaleBypass_ff |-> ch7PrescaleDivide_ff == 2'h1)
    else $error("bypass ratio not one");
  AST_NEG_GATE: assert property (ch7NegativeSideOn_ff |-> ch7PositiveSideOn_ff)
    else $error("negative side on alone");
  AST_DRV_ONEHOT: assert property ($onehot({ch7DriverLvds_ff, ch7DriverLvcmos_ff,
    ch7DriverHcsl_ff})) else $error("driver decode not one-hot");
  AST_INT_DIV: assert property (wrAt(6'h13) |=> ##1 ch7IntegerDivide_ff ==
    {1'b0, $past(regWrData[11:4], 2)} + 9'h001) else $error("integer ratio wrong");
  AST_FRAC_HI: assert property (wrAt(6'h13) |=> ##1
    ch7FractionValue_ff[19:16] == $past(regWrData[3:0], 2)) else $error("fraction high wrong");
  AST_FRAC_LO: assert property (wrAt(6'h14) |=> ##1
    ch7FractionValue_ff[15:0] == $past(regWrData, 2)) else $error("fraction low wrong");
endmodule
bind ocd_channel_config ocd_chk ocd_chk_i (.clk_sys, .resetn, .regWrEn, .regAddr, .regWrData,
  .ch7FractionValue_ff, .ch7IntegerDivide_ff, .ch7FractionEnable_ff, .ch7PrescaleDivide_ff,
  .ch7PrescaleBypass_ff, .ch7PositiveSideOn_ff, .ch7NegativeSideOn_ff, .ch7DriverLvds_ff,
  .ch7DriverLvcmos_ff, .ch7DriverHcsl_ff);
`default_nettype wire

// *** ocd_host.sv ***
// Serial configuration host model that issues register writes and reads.
`timescale 1ns/1ps
`default_nettype none
module ocd_host (
  input  wire logic        clk_sys,
  output var  logic        regWrEn,
  output var  logic        regRdEn,
  output var  logic [5:0]  regAddr,
  output var  logic [15:0] regWrData,
  input  wire logic [15:0] regRdData_ff,
  input  wire logic        regRdValid_ff
);
  initial begin
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    regAddr = 6'h3F;
    regWrData = 16'h0000;
  end
  // Callers also write reserved pre-divider codes and ones in spare bits, in t_control and t_divider.
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(negedge clk_sys);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(negedge clk_sys);
    regWrEn = 1'b0;
    // Released lines show the inverse so stale values cannot pass for held ones.
    regAddr = ~a;
    regWrData = ~d;
  endtask
  task automatic rd(input logic [5:0] a, output logic [15:0] d, output logic v);
    @(negedge clk_sys);
    regAddr = a;
    regRdEn = 1'b1;
    @(negedge clk_sys);
    regRdEn = 1'b0;
    regAddr = ~a;
    d = regRdData_ff;
    v = regRdValid_ff;
  endtask
endmodule
`default_nettype wire

// *** ocd_channel_config_tb_top.sv ***
// Self-checking testbench for the channel 7 configuration registers.
`timescale 1ns/1ps
`default_nettype none
module ocd_channel_config_tb_top;
  logic        clk_sys = 1'b0;
  logic        resetn = 1'b0;
  logic        vcoLowRange = 1'b1;
  logic        regWrEn, regRdEn, regRdValid_ff;
  logic [5:0]  regAddr;
  logic [15:0] regWrData, regRdData_ff;
  logic [19:0] ch6FractionValue_ff, ch7FractionValue_ff;
  logic [8:0]  ch7IntegerDivide_ff;
  logic [1:0]  ch7PrescaleDivide_ff;
  logic        ch7FractionEnable_ff, ch7PrescaleBypass_ff, ch7PrescaleFault_ff;
  logic        ch7SingleEndedSlow_ff, ch7PositiveSideOn_ff, ch7NegativeSideOn_ff;
  logic        ch7DriverLvds_ff, ch7DriverLvcmos_ff, ch7DriverHcsl_ff, ch7OutputClocking_ff;
  logic        ch7OutputStatic_ff, ch7StaticLevel_ff, ch7SupplyHigh_ff;
  int          error_cnt = 0;
  int          tests_run = 0;
  int          cyc = 0;
  always #4 clk_sys = ~clk_sys;
  ocd_host ocd_host_i (.clk_sys, .regWrEn, .regRdEn, .regAddr, .regWrData, .regRdData_ff,
    .regRdValid_ff);
  ocd_channel_config ocd_channel_config_i (.clk_sys, .resetn, .regWrEn, .regRdEn, .regAddr,
    .regWrData, .vcoLowRange, .regRdData_ff, .regRdValid_ff, .ch6FractionValue_ff,
    .ch7FractionValue_ff, .ch7IntegerDivide_ff, .ch7FractionEnable_ff, .ch7PrescaleDivide_ff,
    .ch7PrescaleBypass_ff, .ch7PrescaleFault_ff, .ch7SingleEndedSlow_ff, .ch7PositiveSideOn_ff,
    .ch7NegativeSideOn_ff, .ch7DriverLvds_ff, .ch7DriverLvcmos_ff, .ch7DriverHcsl_ff,
    .ch7OutputClocking_ff, .ch7OutputStatic_ff, .ch7StaticLevel_ff, .ch7SupplyHigh_ff);
  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      wrap_up();
    end
  end
  task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Waits one more edge so the decoded outputs have caught up with the write.
  task automatic wrs(input logic [5:0] a, input logic [15:0] d);
    ocd_host_i.wr(a, d);
    @(negedge clk_sys);
  endtask
  task automatic rdc(input logic [5:0] a, input logic [15:0] e);
    logic [15:0] d;
    logic        v;
    ocd_host_i.rd(a, d, v);
    chk({3'h0, v, d}, {4'h1, e});
  endtask
  task automatic t_reset;
    rdc(6'h12, 16'h0000);
    chk({ch7IntegerDivide_ff, ch7PrescaleDivide_ff, ch7PrescaleBypass_ff, ch7DriverLvds_ff},
      {9'h001, 2'h1, 2'h3});
    $display("t_reset done");
  endtask
  task automatic t_control;
    logic [2:0]  c;
    logic [1:0]  r;
    logic [15:0] w;
    for (int i = 0; i < 8; i++) begin
      c = i[2:0];
      r = (c == 3'h1) ? 2'h3 : ((c == 3'h7) ? 2'h1 : 2'h2);
      w = {3'h7, c, 1'b1, c[0], c[1], c[2], 1'b1, c[1:0], c[2:1], c[0]};
      wrs(6'h12, w);
      rdc(6'h12, w & 16'h1FDF);
      chk({ch7PrescaleDivide_ff, ch7PrescaleFault_ff, ch7FractionEnable_ff, ch7PrescaleBypass_ff},
        {r, !(c == 3'h0 || c == 3'h1 || c == 3'h7), 2'h2});
      chk({ch7SingleEndedSlow_ff, ch7PositiveSideOn_ff, ch7NegativeSideOn_ff, ch7DriverLvds_ff,
        ch7DriverLvcmos_ff, ch7DriverHcsl_ff, ch7OutputClocking_ff, ch7OutputStatic_ff,
        ch7StaticLevel_ff, ch7SupplyHigh_ff}, {c[0], c[2], c[1] & c[2], ~c[1], c[1:0] == 2'h2,
        c[1:0] == 2'h3, c[2:1] == 2'h1, c[2], c[2] & c[1], c[0]});
    end
    vcoLowRange = 1'b0;
    wrs(6'h12, 16'h1E00);
    chk(ch7PrescaleFault_ff, 1'b1);
    wrs(6'h12, 16'h0400);
    chk({ch7PrescaleDivide_ff, ch7PrescaleBypass_ff, ch7PrescaleFault_ff}, 4'h6);
    vcoLowRange = 1'b1;
    $display("t_control done");
  endtask
  task automatic t_divider;
    wrs(6'h13, 16'hFFFF);
    rdc(6'h13, 16'h0FFF);
    chk({ch7IntegerDivide_ff, ch7FractionValue_ff[19:16]}, {9'h100, 4'hF});
    wrs(6'h13, 16'h0005);
    wrs(6'h14, 16'hA5C3);
    chk(ch7FractionValue_ff, 20'h5A5C3);
    chk(ch7IntegerDivide_ff, 9'h001);
    wrs(6'h10, 16'hFFF9);
    wrs(6'h11, 16'h1234);
    chk(ch6FractionValue_ff, 20'h91234);
    rdc(6'h10, 16'h0009);
    wrs(6'h15, 16'hFFFF);
    rdc(6'h15, 16'h0000);
    $display("t_divider done");
  endtask
  initial begin
    repeat (8) @(negedge clk_sys);
    resetn = 1'b1;
    t_reset();
    t_control();
    t_divider();
    wrap_up();
  end
endmodule
`default_nettype wire
